/* File: verilog/two_wire_pkg.sv */
package two_wire_pkg;

	// ***********************************************
	// Bus timing
	// ***********************************************
	localparam int CLK_HZ = 40000000;
	localparam int BUS_HZ = 400000;
	localparam int QTR_CYC = CLK_HZ / (BUS_HZ * 4);
	localparam logic [7:0] QTR_LOAD = 8'(QTR_CYC - 1);

	// ***********************************************
	// Packet framing
	// ***********************************************
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic [3:0] CNT_END = 4'h9;
	localparam logic [6:0] GC_ADDR = 7'h00;
	localparam logic [3:0] RSV_HI = 4'hf;
	localparam int BUF_W = 9;

	// ***********************************************
	// Commands, phases and states
	// ***********************************************
	typedef enum logic [1:0] {
		CMD_START = 2'b00,
		CMD_WRITE = 2'b01,
		CMD_READ = 2'b10,
		CMD_STOP = 2'b11
	} cmd_type;

	typedef enum logic [2:0] {
		P_LOW = 3'b000,
		P_DATA = 3'b001,
		P_REL = 3'b010,
		P_WAIT = 3'b011,
		P_HIGH = 3'b100
	} phase_type;

	typedef enum logic [1:0] {
		MS_IDLE = 2'b00,
		MS_START = 2'b01,
		MS_BITS = 2'b10,
		MS_STOP = 2'b11
	} mst_type;

	typedef enum logic [1:0] {
		SL_IDLE = 2'b00,
		SL_ADDR = 2'b01,
		SL_RX = 2'b10,
		SL_TX = 2'b11
	} slv_type;

endpackage

/* File: verilog/two_entry_buffer.sv */
`timescale 1ns/100ps
`default_nettype none
module two_entry_buffer #(
	parameter int W = 9
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	logic skid_valid_reg;
	logic [W-1:0] skid_data_reg;

	// Full when the skid entry holds a word
	assign in_ready_o = !skid_valid_reg;

	// Output stage refills from skid first, else from input
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else if (out_ready_i || !out_valid_o) begin
			if (skid_valid_reg) begin
				out_valid_o <= 1'b1;
				out_data_o <= skid_data_reg;
			end else begin
				out_valid_o <= in_valid_i;
				out_data_o <= in_data_i;
			end
		end
	end

	// Skid entry catches a word while the output stalls
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			skid_valid_reg <= 1'b0;
			skid_data_reg <= '0;
		end else if (out_ready_i || !out_valid_o) begin
			skid_valid_reg <= 1'b0;
		end else if (in_valid_i && !skid_valid_reg) begin
			skid_valid_reg <= 1'b1;
			skid_data_reg <= in_data_i;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/two_wire_interface.sv */
// Contract
// RULE1: Interface idles while the power gate input is high.
// RULE2: Lines are only pulled low or released, never driven high.
// RULE3: One clock pulse per bit; data changes only with clock low.
// RULE4: Start and stop are data edges while clock is high.
// RULE5: Start is data falling with clock high; stop is data rising.
// RULE6: Bus is busy from start to stop; no new master start then.
// RULE7: Start before stop is a repeated start; bus stays busy.
// RULE8: Address packet: seven bits MSB first, direction bit, acknowledge.
// RULE9: Direction one means read, zero means write.
// RULE10: Addressed slave pulls data low in ninth cycle, else releases.
// RULE11: After address not acknowledged, master sends stop or repeated start.
// RULE12: All-zero address is general call; enabled slaves ack writes.
// RULE13: Masters never send general call with read direction.
// RULE14: Addresses with upper four bits all ones are reserved.
// RULE15: Data packet: eight bits MSB first, then acknowledge.
// RULE16: Master makes clock, start, stop; receiver acks in ninth cycle.
// RULE17: Receiver returns not-acknowledge after its final byte.
// RULE18: Transfer is start, address, data packets, stop; never empty.
// RULE19: Slave may stretch clock low; master waits, sets high time.
// RULE20: Master times clock high only after seeing the line high.
// RULE21: Bus rates up to 400 kHz are supported.
// RULE22: Own address match raises a wake pulse for the processor.
`timescale 1ns/100ps
`default_nettype none
module two_wire_interface
	import two_wire_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic serial_bus_power_gate_i,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic cmd_valid_i,
	input wire logic [1:0] cmd_i,
	input wire logic [7:0] cmd_data_i,
	input wire logic cmd_ack_i,
	output logic cmd_ready_o,
	output logic wr_nack_o,
	input wire logic [6:0] own_addr_i,
	input wire logic gc_enable_i,
	input wire logic slave_ack_en_i,
	input wire logic slave_tx_valid_i,
	input wire logic [7:0] slave_tx_data_i,
	output logic slave_tx_taken_o,
	output logic slave_read_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_from_slave_o,
	input wire logic rx_ready_i,
	output logic addr_match_o,
	output logic bus_busy_o
);
	// ***********************************************
	// Declarations
	// ***********************************************
	logic run;
	logic scl_m_reg, scl_s, sda_m_reg, sda_s, scl_d_reg, sda_d_reg;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic [7:0] qcnt_reg;
	logic tick_reg;
	mst_type m_state;
	phase_type m_ph;
	logic [3:0] m_cnt;
	logic [7:0] m_sh;
	logic m_rd, m_ack, m_scl_reg, m_sda_reg, m_push_reg;
	slv_type s_state;
	logic [3:0] s_cnt;
	logic [7:0] s_sh;
	logic s_rw, s_scl_reg, s_sda_reg, s_push_reg, s_wait_reg;
	logic buf_ready;
	logic push_valid;
	logic [BUF_W-1:0] push_data;
	logic [BUF_W-1:0] buf_out;

	// Address hit on own address or enabled general call write
	function automatic logic addr_hit(input logic [7:0] b,
		input logic [6:0] own, input logic gce);
		logic own_ok;
		own_ok = own[6:3] != RSV_HI; // RULE14
		addr_hit = (b[7:1] == own && own_ok) ||
			(b[7:1] == GC_ADDR && gce && !b[0]); // RULE12
	endfunction

	assign run = !serial_bus_power_gate_i; // RULE1
	// Pin drivers only ever pull low
	assign scl_o = 1'b0; // RULE2
	assign sda_o = 1'b0; // RULE2

	// ***********************************************
	// Pin synchronisers and condition detection
	// ***********************************************
	// Two flip-flops per line, then one delay for edges
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			scl_m_reg <= 1'b1;
			scl_s <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_m_reg <= 1'b1;
			sda_s <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_m_reg <= scl_i;
			scl_s <= scl_m_reg;
			scl_d_reg <= scl_s;
			sda_m_reg <= sda_i;
			sda_s <= sda_m_reg;
			sda_d_reg <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_d_reg;
	assign scl_fall = !scl_s && scl_d_reg;
	// Data edges while clock stays high
	assign start_det = scl_s && scl_d_reg && !sda_s && sda_d_reg; // RULE5
	assign stop_det = scl_s && scl_d_reg && sda_s && !sda_d_reg; // RULE5

	// Busy from any start, repeated or not, until stop
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || !run) begin
			bus_busy_o <= 1'b0;
		end else if (stop_det) begin
			bus_busy_o <= 1'b0;
		end else if (start_det) begin
			bus_busy_o <= 1'b1; // RULE6 RULE7
		end
	end

	// ***********************************************
	// Quarter bit divider
	// ***********************************************
	// Restarts when the clock line is seen high to time the high phase
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || !run) begin
			qcnt_reg <= QTR_LOAD;
			tick_reg <= 1'b0;
		end else if (m_ph == P_WAIT || qcnt_reg == 8'h00) begin
			qcnt_reg <= QTR_LOAD; // RULE20 RULE21
			tick_reg <= m_ph != P_WAIT;
		end else begin
			qcnt_reg <= qcnt_reg - 8'h01;
			tick_reg <= 1'b0;
		end
	end

	// ***********************************************
	// Master sequencer
	// ***********************************************
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || !run) begin
			m_state <= MS_IDLE;
			m_ph <= P_LOW;
			m_cnt <= 4'h0;
			m_sh <= 8'h00;
			m_rd <= 1'b0;
			m_ack <= 1'b0;
			m_scl_reg <= 1'b0;
			m_sda_reg <= 1'b0;
			m_push_reg <= 1'b0;
			cmd_ready_o <= 1'b0;
			wr_nack_o <= 1'b0;
		end else begin
			m_push_reg <= 1'b0;
			if (cmd_ready_o && cmd_valid_i) begin
				// Command taken; idle accepts only a fresh start
				cmd_ready_o <= 1'b0;
				m_ph <= P_DATA;
				m_cnt <= 4'h0;
				m_sh <= cmd_data_i;
				m_rd <= cmd_i == CMD_READ;
				m_ack <= cmd_ack_i; // RULE17
				unique case (cmd_type'(cmd_i))
				CMD_START: m_state <= MS_START; // RULE7
				CMD_WRITE, CMD_READ: begin
					if (m_state != MS_IDLE) begin
						m_state <= MS_BITS;
					end
				end
				CMD_STOP: begin
					if (m_state != MS_IDLE) begin
						m_state <= MS_STOP; // RULE11
					end
				end
				endcase
			end else if (m_state == MS_IDLE) begin
				// No start while another master holds the bus
				cmd_ready_o <= !bus_busy_o && !cmd_ready_o; // RULE6
				m_scl_reg <= 1'b0;
				m_sda_reg <= 1'b0;
			end else if (cmd_ready_o) begin
				m_scl_reg <= 1'b1;
			end else if (m_ph == P_WAIT) begin
				// Wait out any stretch by a slave
				if (scl_s) begin
					m_ph <= P_HIGH; // RULE19 RULE20
				end
			end else if (tick_reg) begin
				unique case (m_ph)
				P_LOW: begin
					m_scl_reg <= 1'b1;
					if (m_state == MS_START || m_cnt == CNT_ACK) begin
						cmd_ready_o <= 1'b1;
					end else begin
						m_cnt <= m_cnt + 4'h1;
						m_ph <= P_DATA;
					end
				end
				P_DATA: begin
					// Data moves only while the clock is low
					if (m_state == MS_START) begin
						m_sda_reg <= 1'b0;
						m_ph <= P_REL;
					end else if (m_state == MS_STOP) begin
						m_sda_reg <= 1'b1;
						m_ph <= P_REL;
					end else if (m_cnt != CNT_ACK) begin
						m_sda_reg <= !m_rd && !m_sh[7]; // RULE3 RULE8 RULE15
						m_ph <= P_REL;
					end else if (!m_rd) begin
						m_sda_reg <= 1'b0;
						m_ph <= P_REL;
					end else if (buf_ready) begin
						// Byte handed on before the ack is clocked
						m_sda_reg <= m_ack; // RULE16 RULE17
						m_push_reg <= 1'b1;
						m_ph <= P_REL;
					end
				end
				P_REL: begin
					m_scl_reg <= 1'b0;
					m_ph <= P_WAIT;
				end
				default: begin
					// Mid high: form conditions or sample
					m_ph <= P_LOW;
					if (m_state == MS_START) begin
						m_sda_reg <= 1'b1; // RULE4 RULE5
					end else if (m_state == MS_STOP) begin
						m_sda_reg <= 1'b0; // RULE4 RULE5
						m_state <= MS_IDLE;
					end else if (m_cnt != CNT_ACK) begin
						m_sh <= {m_sh[6:0], sda_s};
					end else if (!m_rd) begin
						wr_nack_o <= sda_s; // RULE16
					end
				end
				endcase
			end
		end
	end

	// ***********************************************
	// Slave framing
	// ***********************************************
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || !run) begin
			s_state <= SL_IDLE;
			s_cnt <= 4'h0;
			s_sh <= 8'h00;
			s_rw <= 1'b0;
			s_scl_reg <= 1'b0;
			s_sda_reg <= 1'b0;
			s_push_reg <= 1'b0;
			s_wait_reg <= 1'b0;
			addr_match_o <= 1'b0;
			slave_tx_taken_o <= 1'b0;
		end else begin
			s_push_reg <= 1'b0;
			addr_match_o <= 1'b0;
			slave_tx_taken_o <= 1'b0;
			if (m_state != MS_IDLE || stop_det) begin
				s_state <= SL_IDLE;
				s_scl_reg <= 1'b0;
				s_sda_reg <= 1'b0;
				s_wait_reg <= 1'b0;
			end else if (start_det) begin
				s_state <= SL_ADDR; // RULE7
				s_cnt <= 4'h0;
				s_sda_reg <= 1'b0;
				s_scl_reg <= 1'b0;
				s_wait_reg <= 1'b0;
			end else if (s_wait_reg) begin
				// Clock held low until the user side can go on
				if (s_state == SL_RX && buf_ready) begin
					s_push_reg <= 1'b1;
					s_sda_reg <= slave_ack_en_i; // RULE16 RULE17
					s_scl_reg <= 1'b0;
					s_wait_reg <= 1'b0;
				end else if (s_state == SL_TX && slave_tx_valid_i) begin
					s_sh <= slave_tx_data_i;
					s_sda_reg <= !slave_tx_data_i[7];
					slave_tx_taken_o <= 1'b1;
					s_scl_reg <= 1'b0;
					s_wait_reg <= 1'b0;
				end
			end else if (s_state != SL_IDLE && scl_rise) begin
				if (s_cnt == CNT_ACK) begin
					s_cnt <= CNT_END;
					if (s_state == SL_TX && sda_s) begin
						s_state <= SL_IDLE; // RULE17
					end
				end else begin
					s_cnt <= s_cnt + 4'h1;
					if (s_state == SL_TX) begin
						s_sh <= {s_sh[6:0], 1'b0};
					end else begin
						s_sh <= {s_sh[6:0], sda_s}; // RULE8 RULE15
					end
				end
			end else if (s_state != SL_IDLE && scl_fall) begin
				if (s_cnt == CNT_ACK) begin
					unique case (s_state)
					SL_ADDR: begin
						if (addr_hit(s_sh, own_addr_i, gc_enable_i)) begin
							s_sda_reg <= slave_ack_en_i; // RULE10 RULE12
							addr_match_o <= 1'b1; // RULE22
							s_rw <= s_sh[0]; // RULE9
						end else begin
							s_state <= SL_IDLE; // RULE10
						end
					end
					SL_RX: begin
						s_scl_reg <= 1'b1; // RULE19
						s_wait_reg <= 1'b1;
					end
					default: s_sda_reg <= 1'b0;
					endcase
				end else if (s_cnt == CNT_END) begin
					s_cnt <= 4'h0;
					s_sda_reg <= 1'b0;
					if (s_state == SL_ADDR && !s_sda_reg) begin
						s_state <= SL_IDLE;
					end else if (s_state == SL_ADDR && !s_rw) begin
						s_state <= SL_RX;
					end else if (s_state != SL_RX) begin
						s_state <= SL_TX;
						s_scl_reg <= 1'b1; // RULE19
						s_wait_reg <= 1'b1;
					end
				end else if (s_state == SL_TX && s_cnt != 4'h0) begin
					s_sda_reg <= !s_sh[7]; // RULE3
				end
			end
		end
	end

	assign slave_read_o = s_rw;

	// ***********************************************
	// Pin drive and receive buffer
	// ***********************************************
	// Wired-AND of master and slave pull-downs
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || !run) begin
			scl_oe_o <= 1'b0; // RULE1
			sda_oe_o <= 1'b0;
		end else begin
			scl_oe_o <= m_scl_reg || s_scl_reg; // RULE2
			sda_oe_o <= m_sda_reg || s_sda_reg; // RULE2
		end
	end

	assign push_valid = m_push_reg || s_push_reg;
	assign push_data = {s_push_reg, m_push_reg ? m_sh : s_sh};

	two_entry_buffer #(.W(BUF_W)) rx_buf (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.in_valid_i(push_valid),
		.in_data_i(push_data),
		.in_ready_o(buf_ready),
		.out_valid_o(rx_valid_o),
		.out_data_o(buf_out),
		.out_ready_i(rx_ready_i)
	);

	assign rx_data_o = buf_out[7:0];
	assign rx_from_slave_o = buf_out[8];

	// ***********************************************
	// Assertions
	// ***********************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	sequence s_gated;
		serial_bus_power_gate_i ##1 serial_bus_power_gate_i;
	endsequence
	property p_gate_idle;
		s_gated |=> !scl_oe_o && !sda_oe_o && !cmd_ready_o;
	endproperty
	a_gate_idle: assert property (p_gate_idle) // RULE1
		else $error("bus driven while gated");

	property p_data_steady;
		m_state == MS_BITS && m_ph inside {P_WAIT, P_HIGH} && !tick_reg
			|=> $stable(m_sda_reg);
	endproperty
	a_data_steady: assert property (p_data_steady) // RULE3
		else $error("data moved with clock high");

	sequence s_start_high;
		m_state == MS_START && m_ph == P_HIGH && tick_reg;
	endsequence
	property p_start_form;
		s_start_high |=> m_sda_reg && !m_scl_reg ##1 sda_oe_o;
	endproperty
	a_start_form: assert property (p_start_form) // RULE5
		else $error("start not formed with clock high");

	property p_stretch_wait;
		m_ph == P_WAIT && !scl_s |=> m_ph == P_WAIT;
	endproperty
	a_stretch_wait: assert property (p_stretch_wait) // RULE20
		else $error("master went on while clock held low");

	property p_busy_track;
		(start_det |=> bus_busy_o) and (stop_det |=> !bus_busy_o);
	endproperty
	a_busy_track: assert property (p_busy_track) // RULE6
		else $error("busy flag wrong");

	property p_no_start_busy;
		m_state == MS_IDLE && bus_busy_o |-> ##1 !cmd_ready_o;
	endproperty
	a_no_start_busy: assert property (p_no_start_busy) // RULE6
		else $error("start offered on busy bus");

	property p_bit_count;
		m_state == MS_BITS |-> m_cnt <= CNT_ACK;
	endproperty
	a_bit_count: assert property (p_bit_count) // RULE15
		else $error("packet longer than nine bits");

	property p_reserved;
		addr_match_o && own_addr_i[6:3] == RSV_HI |-> $past(s_sh[7:1]) == GC_ADDR;
	endproperty
	a_reserved: assert property (p_reserved) // RULE14
		else $error("reserved address matched");

	property p_ack_drive;
		addr_match_o && slave_ack_en_i |-> ##1 sda_oe_o;
	endproperty
	a_ack_drive: assert property (p_ack_drive) // RULE10
		else $error("matched address not acknowledged");

	property p_gc_write;
		addr_match_o && $past(s_sh[7:1]) == GC_ADDR |-> !$past(s_sh[0]);
	endproperty
	a_gc_write: assert property (p_gc_write) // RULE12
		else $error("general call read acknowledged");
endmodule
`default_nettype wire

/* File: bench/bus_slave_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bus_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a,
	parameter int STRETCH_NS = 3000
) (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic stretch_i,
	input wire logic [7:0] tx_byte_i,
	output logic scl_oe_o,
	output logic sda_oe_o,
	output logic [7:0] rx_byte_o,
	output logic last_ack_o
);
	// ***********************************************
	// Far-side slave, behavioural
	// ***********************************************
	int bitn = 0;
	logic [7:0] sh = 8'h00;
	logic act = 1'b0;
	logic adr = 1'b0;
	logic me = 1'b0;
	logic rd = 1'b0;

	// Released lines and cleared results at start of run
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
		rx_byte_o = 8'h00;
		last_ack_o = 1'b1;
	end

	// Start or repeated start: data falls with clock high
	always @(negedge sda_i) if (scl_i) begin
		act = 1'b1;
		adr = 1'b1;
		me = 1'b1;
		rd = 1'b0;
		bitn = 0;
	end

	// Stop: data rises with clock high, let go of the line
	always @(posedge sda_i) if (scl_i) begin
		act = 1'b0;
		sda_oe_o = 1'b0;
	end

	// Sample on the rising clock: bits, then the master's ack
	always @(posedge scl_i) if (act) begin
		if (bitn < 8) begin
			sh = {sh[6:0], sda_i};
		end else if (rd && !adr) begin
			last_ack_o = sda_i;
			me = me && !sda_i;
		end
		bitn = bitn + 1;
		if (bitn == 8 && adr) begin
			me = (sh[7:1] == ADDR);
			rd = sh[0];
		end
	end

	// Drive only while the clock is low, pull low or release
	always @(negedge scl_i) if (act) begin
		if (bitn == 9) begin
			bitn = 0;
			adr = 1'b0;
		end
		if (bitn == 8 && !adr && !rd) rx_byte_o = sh;
		if (bitn == 8) sda_oe_o = me && (adr || !rd);
		else sda_oe_o = me && rd && !adr && !tx_byte_i[3'(7 - bitn)];
		if (stretch_i) begin
			scl_oe_o = 1'b1;
			#(STRETCH_NS);
			scl_oe_o = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: bench/two_wire_interface_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module two_wire_interface_tb
	import two_wire_pkg::*;
;
	localparam int LIM = 40000;
	// ***********************************************
	// Signals and instances
	// ***********************************************
	logic clk_sys_i, resetn_i, serial_bus_power_gate_i, cmd_valid_i;
	logic cmd_ack_i, gc_enable_i, slave_ack_en_i, slave_tx_valid_i;
	logic rx_ready_i, scl_o, scl_oe_o, sda_o, sda_oe_o, cmd_ready_o;
	logic wr_nack_o, slave_tx_taken_o, slave_read_o, rx_valid_o;
	logic rx_from_slave_o, addr_match_o, bus_busy_o;
	logic tb_scl, tb_sda, m_scl, m_sda, m_ack, stretch, ak;
	logic [1:0] cmd_i;
	logic [7:0] cmd_data_i, slave_tx_data_i, rx_data_o, m_tx, m_rx, q;
	logic [6:0] own_addr_i;
	logic [16:0] rows [5] = '{{7'h35, 1'b0, 7'h35, 1'b1, 1'b0},
		{7'h00, 1'b1, 7'h35, 1'b1, 1'b0}, {7'h00, 1'b0, 7'h35, 1'b1, 1'b1},
		{7'h7a, 1'b0, 7'h7a, 1'b1, 1'b1}, {7'h35, 1'b0, 7'h35, 1'b0, 1'b1}};
	int n_fail = 0, compares = 0, n_start = 0, n_stop = 0, n_match = 0;
	int n_taken = 0;
	// Wired-AND lines with pull-ups
	wire logic scl = !(scl_oe_o | m_scl | tb_scl);
	wire logic sda = !(sda_oe_o | m_sda | tb_sda);

	two_wire_interface dut (.clk_sys_i, .resetn_i, .serial_bus_power_gate_i,
		.scl_i(scl), .scl_o, .scl_oe_o, .sda_i(sda), .sda_o, .sda_oe_o,
		.cmd_valid_i, .cmd_i, .cmd_data_i, .cmd_ack_i, .cmd_ready_o,
		.wr_nack_o, .own_addr_i, .gc_enable_i, .slave_ack_en_i,
		.slave_tx_valid_i, .slave_tx_data_i, .slave_tx_taken_o,
		.slave_read_o, .rx_valid_o, .rx_data_o, .rx_from_slave_o,
		.rx_ready_i, .addr_match_o, .bus_busy_o);
	bus_slave_model #(.ADDR(7'h2a)) far (.scl_i(scl), .sda_i(sda),
		.stretch_i(stretch), .tx_byte_i(m_tx), .scl_oe_o(m_scl),
		.sda_oe_o(m_sda), .rx_byte_o(m_rx), .last_ack_o(m_ack));

	// Clock
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = !clk_sys_i;
	end

	// Count start and stop conditions on the wire
	always @(negedge sda) if (scl === 1'b1) n_start++;
	always @(posedge sda) if (scl === 1'b1) n_stop++;
	// Count one-cycle pulses, sampled away from the launching edge
	always @(negedge clk_sys_i) begin
		if (addr_match_o === 1'b1) n_match++;
		if (slave_tx_taken_o === 1'b1) n_taken++;
	end

	// ***********************************************
	// Shared tasks
	// ***********************************************
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic summarize;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic tmo;
		chk(9'h0, 9'h1);
		summarize();
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	task automatic rdy;
		int k = 0;
		while (cmd_ready_o !== 1'b1 && k < LIM) begin
			@(negedge clk_sys_i);
			k++;
		end
		if (k == LIM) tmo();
	endtask

	// Master command, held until taken; w waits for completion
	task automatic cmd(input logic [1:0] c, input logic [7:0] d,
		input logic a, input logic w);
		@(negedge clk_sys_i);
		cmd_i = c;
		cmd_data_i = d;
		cmd_ack_i = a;
		cmd_valid_i = 1'b1;
		rdy();
		@(negedge clk_sys_i);
		cmd_valid_i = 1'b0;
		if (w) rdy();
	endtask

	task automatic pop(input logic [8:0] e);
		int k = 0;
		while (rx_valid_o !== 1'b1 && k < LIM) begin
			@(negedge clk_sys_i);
			k++;
		end
		if (k == LIM) tmo();
		chk({rx_from_slave_o, rx_data_o}, e);
		rx_ready_i = 1'b1;
		@(negedge clk_sys_i);
		rx_ready_i = 1'b0;
	endtask

	// Release the clock and wait for it to rise, the slave may stretch
	task automatic hi;
		int k = 0;
		tb_scl = 1'b0;
		while (scl !== 1'b1 && k < LIM) begin
			#25;
			k++;
		end
		if (k == LIM) tmo();
	endtask

	// One bit as bench master, 200 ns period
	task automatic mbit(input logic b, output logic r);
		tb_sda = !b;
		#50;
		hi();
		#50;
		r = sda;
		#50;
		tb_scl = 1'b1;
		#50;
	endtask

	task automatic mbyte(input logic [7:0] d, input logic a);
		for (int i = 7; i >= 0; i--) mbit(d[i], q[i]);
		mbit(a, ak);
	endtask

	task automatic mstart;
		tb_sda = 1'b1;
		#100;
		tb_scl = 1'b1;
		#50;
	endtask

	task automatic mstop;
		tb_sda = 1'b1;
		#50;
		hi();
		#100;
		tb_sda = 1'b0;
		#100;
	endtask

	// ***********************************************
	// Scenarios
	// ***********************************************
	task automatic t_gate;
		int k = 0;
		serial_bus_power_gate_i = 1'b1;
		cmd_valid_i = 1'b1;
		repeat (200) begin
			@(negedge clk_sys_i);
			k += int'(sda_oe_o | scl_oe_o | cmd_ready_o);
		end
		chk(9'(k), 9'h0);
		cmd_valid_i = 1'b0;
		serial_bus_power_gate_i = 1'b0;
		cyc(4);
		$display("gate test done");
	endtask

	task automatic t_mwrite;
		int s0 = n_start;
		int p0 = n_stop;
		stretch = 1'b1;
		cmd(CMD_START, 8'h00, 1'b0, 1'b1);
		chk(bus_busy_o, 1'b1);
		cmd(CMD_WRITE, {7'h2a, 1'b0}, 1'b0, 1'b1);
		chk(wr_nack_o, 1'b0);
		cmd(CMD_WRITE, 8'ha5, 1'b0, 1'b1);
		chk({wr_nack_o, m_rx}, 9'h0a5);
		stretch = 1'b0;
		cmd(CMD_STOP, 8'h00, 1'b0, 1'b1);
		cyc(10);
		chk({bus_busy_o, scl, sda}, 9'h3);
		chk(9'(n_start - s0), 9'h1);
		chk(9'(n_stop - p0), 9'h1);
		$display("master write test done");
	endtask

	task automatic t_mnack;
		int s0;
		cmd(CMD_START, 8'h00, 1'b0, 1'b1);
		cmd(CMD_WRITE, {7'h11, 1'b0}, 1'b0, 1'b1);
		chk(wr_nack_o, 1'b1);
		s0 = n_start;
		cmd(CMD_START, 8'h00, 1'b0, 1'b1);
		chk(bus_busy_o, 1'b1);
		chk(9'(n_start - s0), 9'h1);
		cmd(CMD_WRITE, {7'h2a, 1'b0}, 1'b0, 1'b1);
		chk(wr_nack_o, 1'b0);
		cmd(CMD_STOP, 8'h00, 1'b0, 1'b1);
		$display("master nack test done");
	endtask

	task automatic t_mread;
		m_tx = 8'h3c;
		cmd(CMD_START, 8'h00, 1'b0, 1'b1);
		cmd(CMD_WRITE, {7'h2a, 1'b1}, 1'b0, 1'b1);
		chk(wr_nack_o, 1'b0);
		cmd(CMD_READ, 8'h00, 1'b1, 1'b1);
		cmd(CMD_READ, 8'h00, 1'b1, 1'b1);
		chk(m_ack, 1'b0);
		cmd(CMD_READ, 8'h00, 1'b0, 1'b0);
		// Long enough for all eight bits, so only the full buffer holds it
		cyc(1500);
		chk(cmd_ready_o, 1'b0);
		repeat (3) pop({1'b0, 8'h3c});
		rdy();
		chk(m_ack, 1'b1);
		cmd(CMD_STOP, 8'h00, 1'b0, 1'b1);
		$display("master read test done");
	endtask

	task automatic t_swrite;
		int m0 = n_match;
		mstart();
		mbyte({7'h35, 1'b0}, 1'b1);
		chk(ak, 1'b0);
		mbyte(8'hc3, 1'b1);
		chk(ak, 1'b0);
		mstop();
		pop({1'b1, 8'hc3});
		chk(9'(n_match - m0), 9'h1);
		chk(slave_read_o, 1'b0);
		$display("slave write test done");
	endtask

	task automatic t_sread;
		int t0 = n_taken;
		mstart();
		mbyte({7'h35, 1'b1}, 1'b1);
		chk(ak, 1'b0);
		chk({bus_busy_o, cmd_ready_o}, 9'h2);
		mbyte(8'hff, 1'b0);
		chk(q, 8'h96);
		mbyte(8'hff, 1'b1);
		chk(q, 8'h96);
		mstop();
		chk(9'(n_taken - t0), 9'h2);
		chk(slave_read_o, 1'b1);
		$display("slave read test done");
	endtask

	// Own, general call on and off, reserved, refusing slave
	task automatic t_saddr;
		for (int i = 0; i < 5; i++) begin
			gc_enable_i = rows[i][9];
			own_addr_i = rows[i][8:2];
			slave_ack_en_i = rows[i][1];
			mstart();
			mbyte({rows[i][16:10], 1'b0}, 1'b1);
			chk(ak, rows[i][0]);
			mstop();
		end
		own_addr_i = 7'h35;
		slave_ack_en_i = 1'b1;
		$display("slave address test done");
	endtask

	// ***********************************************
	// Main sequence
	// ***********************************************
	initial begin
		{resetn_i, serial_bus_power_gate_i, cmd_valid_i, cmd_ack_i} = '0;
		{gc_enable_i, tb_scl, tb_sda, stretch, rx_ready_i} = '0;
		{cmd_i, cmd_data_i, m_tx} = '0;
		own_addr_i = 7'h35;
		slave_ack_en_i = 1'b1;
		slave_tx_valid_i = 1'b1;
		slave_tx_data_i = 8'h96;
		cyc(10);
		chk({scl_o, sda_o, scl_oe_o, sda_oe_o, rx_valid_o}, 9'h0);
		resetn_i = 1'b1;
		cyc(4);
		t_gate();
		t_mwrite();
		t_mnack();
		t_mread();
		t_swrite();
		t_sread();
		t_saddr();
		summarize();
	end
endmodule
`default_nettype wire
